// [rtl/mcu_reset_sequencer.sv]
// reset sequencer: cause flags, start-up and option-load delays, initial values
`timescale 1ns/1ps
// How it works
// - pin reset running or halted, or watchdog timeout running, gives a full chip reset
// - watchdog timeout while halted clears only pc and sp
// - power-up clears both flags; pin-run keeps them; pin-wake gives 0,1
// - watchdog-run sets timeout_flag; watchdog-wake sets both flags
// - start-up timer holds execution 1024 clocks after any reset or wake
// - start-up delay runs inside reset; every halt wake-up starts it
// - option-load delay follows chip resets, never warm resets
// - chip reset: pc 000, interrupts off, prescaler clear, timers off, ports input
// - chip reset clears watchdog, which counts again after release
// - chip reset sets stack pointer to top of stack
// - non-warm reset loads documented initial register values; warm keeps them
// - flags readable so software can tell reset causes apart
// - powerdown_flag cleared by power-up and watchdog clear, set by halt
// - entering halt sets powerdown_flag and clears timeout_flag
// - watchdog timeout sets timeout_flag; watchdog halt wake resets only pc and sp
module mcu_reset_sequencer
    import rst_seq_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        ext_reset_pin_n,
    input  wire logic        wdt_timeout,
    input  wire logic        halt_exec,
    input  wire logic        wdt_clear_exec,
    input  wire logic        wake_event,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    output logic             irq,
    output logic             halted,
    output logic             chip_reset,
    output logic             cpu_hold,
    output logic             pc_sp_clear,
    output logic             wdt_clear,
    output logic             int_disable,
    output logic             prescaler_clear,
    output logic             timers_off,
    output logic             ports_input,
    output logic             timeout_flag,
    output logic             powerdown_flag,
    output logic [11:0]      pc_reset_value,
    output logic [3:0]       sp_reset_value,
    output logic [2:0]       watchdog_prescale_select,
    output logic [7:0]       timer0_control,
    output logic [5:0]       watchdog_control,
    output logic [7:0]       io_port_latch,
    output logic [7:0]       io_port_direction
);
    import rst_seq_pkg::*;

    logic       pin_s1_q;
    logic       pin_s2_q;
    logic       wdt_s1_q;
    logic       wdt_s2_q;
    logic       wdt_prev_q;
    seq_state_t state_q;
    seq_state_t state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [3:0] status_q;
    logic [3:0] mask_q;

    // pin and watchdog come from outside this clock domain
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_s1_q   <= 1'b0;
            pin_s2_q   <= 1'b0;
            wdt_s1_q   <= 1'b0;
            wdt_s2_q   <= 1'b0;
            wdt_prev_q <= 1'b0;
        end
        else
        begin
            pin_s1_q   <= ext_reset_pin_n;
            pin_s2_q   <= pin_s1_q;
            wdt_s1_q   <= wdt_timeout;
            wdt_s2_q   <= wdt_s1_q;
            wdt_prev_q <= wdt_s2_q;
        end
    end

    wire pin_low   = !pin_s2_q;
    wire wdt_rise  = wdt_s2_q && !wdt_prev_q;
    wire running   = (state_q == ST_RUN) && !halted;
    // pin wins over the watchdog in the same cycle
    wire ev_pin_run  = pin_low && running;
    wire ev_pin_halt = pin_low && halted;
    wire ev_wdt_run  = !pin_low && wdt_rise && running;
    wire ev_wdt_halt = !pin_low && wdt_rise && halted;
    wire ev_wake     = !pin_low && !wdt_rise && halted && wake_event;
    wire full_reset  = ev_pin_run || ev_pin_halt || ev_wdt_run;
    wire startup_last = (state_q == ST_STARTUP) && (cnt_q == CNT_W'(STARTUP_CLOCKS - 1));
    wire optload_last = (state_q == ST_OPTLOAD) && (cnt_q == CNT_W'(OPTLOAD_CYCLES - 1));
    logic warm_q;

    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q + CNT_W'(1);
        case (state_q)
            ST_HOLD:
            begin
                cnt_d = '0;
                if (!pin_low)
                    state_d = ST_STARTUP;
            end
            ST_STARTUP:
                if (startup_last)
                begin
                    cnt_d   = '0;
                    state_d = warm_q ? ST_RUN : ST_OPTLOAD;
                end
            ST_OPTLOAD:
                if (optload_last)
                begin
                    cnt_d   = '0;
                    state_d = ST_RUN;
                end
            default:
                cnt_d = '0;
        endcase
        if (pin_low)
        begin
            state_d = ST_HOLD;
            cnt_d   = '0;
        end
        else if (ev_wdt_run)
        begin
            state_d = ST_STARTUP;
            cnt_d   = '0;
        end
        else if (ev_wdt_halt || ev_wake)
        begin
            state_d = ST_STARTUP;
            cnt_d   = '0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= ST_HOLD;
            cnt_q   <= '0;
            warm_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            // a pin held low during a warm start-up still makes a chip reset
            if (full_reset || pin_low)
                warm_q <= 1'b0;
            else if (ev_wdt_halt || ev_wake)
                warm_q <= 1'b1;
        end
    end

    // halt status and cause flags; power-up state is the async reset value
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            halted         <= 1'b0;
            timeout_flag   <= 1'b0;
            powerdown_flag <= 1'b0;
        end
        else
        begin
            if (ev_pin_halt)
            begin
                halted         <= 1'b0;
                timeout_flag   <= 1'b0;
                powerdown_flag <= 1'b1;
            end
            else if (ev_wdt_halt)
            begin
                halted         <= 1'b0;
                timeout_flag   <= 1'b1;
                powerdown_flag <= 1'b1;
            end
            else if (ev_wdt_run)
                timeout_flag <= 1'b1;
            else if (ev_wake)
                halted <= 1'b0;
            else if (running && halt_exec)
            begin
                halted         <= 1'b1;
                powerdown_flag <= 1'b1;
                timeout_flag   <= 1'b0;
            end
            else if (running && wdt_clear_exec)
                powerdown_flag <= 1'b0;
        end
    end

    wire in_seq   = (state_q != ST_RUN);
    wire chip_seq = in_seq && !warm_q;
    wire load_init = full_reset || (state_q == ST_HOLD);

    // reset strobes and initial values, all registered
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            chip_reset               <= 1'b1;
            cpu_hold                 <= 1'b1;
            pc_sp_clear              <= 1'b1;
            wdt_clear                <= 1'b1;
            int_disable              <= 1'b1;
            prescaler_clear          <= 1'b1;
            timers_off               <= 1'b1;
            ports_input              <= 1'b1;
            pc_reset_value           <= PC_RESET;
            sp_reset_value           <= SP_TOP;
            watchdog_prescale_select <= WDT_PRESCALE_RST;
            timer0_control           <= TIMER0_CONTROL_RST;
            watchdog_control         <= WATCHDOG_CONTROL_RST;
            io_port_latch            <= PORT_LATCH_RST;
            io_port_direction        <= PORT_DIR_RST;
        end
        else
        begin
            chip_reset      <= pin_low || full_reset || (chip_seq && state_d != ST_RUN);
            cpu_hold        <= state_d != ST_RUN;
            // a plain wake resumes at the next instruction, so pc and sp stay
            pc_sp_clear     <= state_d != ST_RUN && (pin_low || full_reset || chip_seq || ev_wdt_halt);
            wdt_clear       <= pin_low || full_reset || chip_seq;
            int_disable     <= pin_low || full_reset || chip_seq;
            prescaler_clear <= pin_low || full_reset || chip_seq;
            timers_off      <= pin_low || full_reset || chip_seq;
            ports_input     <= pin_low || full_reset || chip_seq;
            if (load_init)
            begin
                pc_reset_value           <= PC_RESET;
                sp_reset_value           <= SP_TOP;
                watchdog_prescale_select <= WDT_PRESCALE_RST;
                timer0_control           <= TIMER0_CONTROL_RST;
                watchdog_control         <= WATCHDOG_CONTROL_RST;
                io_port_latch            <= PORT_LATCH_RST;
                io_port_direction        <= PORT_DIR_RST;
            end
        end
    end

    // event status, write one to clear; a new event beats the clear
    wire [3:0] ev_vec = {ev_wdt_halt, ev_wdt_run, ev_pin_halt, ev_pin_run};
    wire       wr_status = reg_wr && (reg_addr == REG_STATUS);
    wire       wr_mask   = reg_wr && (reg_addr == REG_MASK);
    wire [7:0] rd_mux =
        (reg_addr == REG_STATUS) ? {4'h0, status_q} :
        (reg_addr == REG_MASK)   ? {4'h0, mask_q} :
        (reg_addr == REG_FLAGS)  ? {5'h00, halted, powerdown_flag, timeout_flag} :
                                   8'h00;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            status_q  <= 4'h0;
            mask_q    <= 4'h0;
            reg_rdata <= 8'h00;
            irq       <= 1'b0;
        end
        else
        begin
            status_q  <= (status_q & ~(wr_status ? reg_wdata[3:0] : 4'h0)) | ev_vec;
            if (wr_mask)
                mask_q <= reg_wdata[3:0];
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
            irq       <= |(((status_q & ~(wr_status ? reg_wdata[3:0] : 4'h0)) | ev_vec) & mask_q);
        end
    end

    a_startup_length: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(state_q == ST_STARTUP) && !pin_low |-> (state_q == ST_STARTUP) [*8])
        else $error("startup window ended too soon");
    a_warm_skips_opt: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_q == ST_STARTUP) && warm_q && startup_last && !pin_low |=> state_q == ST_RUN)
        else $error("warm reset took option load delay");
    a_chip_takes_opt: assert property (@(posedge core_clk) disable iff (!arst_n)
        startup_last && !warm_q && !pin_low |=> state_q == ST_OPTLOAD)
        else $error("chip reset skipped option load");
    a_pin_holds: assert property (@(posedge core_clk) disable iff (!arst_n)
        pin_low |=> state_q == ST_HOLD ##1 chip_reset)
        else $error("pin low did not hold reset");
    a_wdt_halt_flags: assert property (@(posedge core_clk) disable iff (!arst_n)
        ev_wdt_halt |=> timeout_flag && powerdown_flag && !halted)
        else $error("watchdog wake flags wrong");
    a_pin_wake_flags: assert property (@(posedge core_clk) disable iff (!arst_n)
        ev_pin_halt |=> !timeout_flag && powerdown_flag)
        else $error("pin wake flags wrong");
    a_halt_flags: assert property (@(posedge core_clk) disable iff (!arst_n)
        running && halt_exec && !pin_low && !wdt_rise |=> halted && powerdown_flag && !timeout_flag)
        else $error("halt entry flags wrong");
    a_warm_keeps_regs: assert property (@(posedge core_clk) disable iff (!arst_n)
        ev_wdt_halt |=> $stable(io_port_direction) && $stable(timer0_control))
        else $error("warm reset changed registers");
    a_chip_loads_init: assert property (@(posedge core_clk) disable iff (!arst_n)
        full_reset |=> io_port_direction == PORT_DIR_RST && watchdog_control == WATCHDOG_CONTROL_RST)
        else $error("chip reset missed initial values");
endmodule

// [rtl/rst_seq_pkg.sv]
// constants for the reset sequencer
package rst_seq_pkg;
    localparam int unsigned CLK_MHZ          = 200;
    localparam int unsigned STARTUP_CLOCKS   = 1024;
    localparam int unsigned OPTLOAD_NS       = 100;
    localparam int unsigned OPTLOAD_CYCLES   = (OPTLOAD_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CNT_W            = 11;
    localparam logic [11:0] PC_RESET         = 12'h000;
    localparam logic [3:0]  SP_TOP           = 4'h0;
    localparam logic [2:0]  WDT_PRESCALE_RST = 3'b111;
    localparam logic [7:0]  TIMER0_CONTROL_RST        = 8'h08;
    localparam logic [5:0]  WATCHDOG_CONTROL_RST         = 6'h2A;
    localparam logic [7:0]  PORT_LATCH_RST   = 8'hFF;
    localparam logic [7:0]  PORT_DIR_RST     = 8'hFF;
    localparam logic [3:0]  REG_STATUS       = 4'h0;
    localparam logic [3:0]  REG_MASK         = 4'h1;
    localparam logic [3:0]  REG_FLAGS        = 4'h2;
    localparam int unsigned EV_PIN_RUN       = 0;
    localparam int unsigned EV_PIN_HALT      = 1;
    localparam int unsigned EV_WDT_RUN       = 2;
    localparam int unsigned EV_WDT_HALT      = 3;
    typedef enum logic [3:0] {
        ST_HOLD    = 4'b0001,
        ST_STARTUP = 4'b0010,
        ST_OPTLOAD = 4'b0100,
        ST_RUN     = 4'b1000
    } seq_state_t;
endpackage

// [testbench/reset_wdt_model.sv]
// far-side model: reset pin driver and watchdog overflow source
`timescale 1ns/1ps
module reset_wdt_model (
    input  wire logic core_clk,
    input  wire logic pin_req,
    input  wire logic wdt_fire,
    input  wire logic wdt_clear,
    output logic      ext_reset_pin_n,
    output logic      wdt_timeout
);
    logic [2:0] pulse_q;
    // pin has a pull-up, so it idles high
    assign ext_reset_pin_n = ~pin_req;
    // held 4 cycles so the 2-flop sync cannot miss it
    assign wdt_timeout = |pulse_q;
    always_ff @(posedge core_clk)
    begin
        if (wdt_clear)
            pulse_q <= 3'h0;
        else if (wdt_fire)
            pulse_q <= 3'h4;
        else if (pulse_q != 3'h0)
            pulse_q <= pulse_q - 3'h1;
    end
endmodule

// [testbench/mcu_reset_sequencer_tb_top.sv]
// self-checking bench for the reset sequencer
`timescale 1ns/1ps
module mcu_reset_sequencer_tb_top;
    import rst_seq_pkg::*;
    logic        core_clk, arst_n, ext_reset_pin_n, wdt_timeout, halt_exec, wdt_clear_exec, wake_event;
    logic        reg_wr, reg_rd, pin_req, wdt_fire;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, timer0_control, io_port_latch, io_port_direction, d, e;
    logic        irq, halted, chip_reset, cpu_hold, pc_sp_clear, wdt_clear, int_disable;
    logic        prescaler_clear, timers_off, ports_input, timeout_flag, powerdown_flag;
    logic [11:0] pc_reset_value;
    logic [3:0]  sp_reset_value;
    logic [2:0]  watchdog_prescale_select;
    logic [5:0]  watchdog_control;
    int          fail_count, samples_checked, seed, cycles;

    mcu_reset_sequencer uut (.core_clk(core_clk), .arst_n(arst_n), .ext_reset_pin_n(ext_reset_pin_n),
        .wdt_timeout(wdt_timeout), .halt_exec(halt_exec), .wdt_clear_exec(wdt_clear_exec),
        .wake_event(wake_event), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .halted(halted), .chip_reset(chip_reset),
        .cpu_hold(cpu_hold), .pc_sp_clear(pc_sp_clear), .wdt_clear(wdt_clear), .int_disable(int_disable),
        .prescaler_clear(prescaler_clear), .timers_off(timers_off), .ports_input(ports_input),
        .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .pc_reset_value(pc_reset_value),
        .sp_reset_value(sp_reset_value), .watchdog_prescale_select(watchdog_prescale_select),
        .timer0_control(timer0_control), .watchdog_control(watchdog_control),
        .io_port_latch(io_port_latch), .io_port_direction(io_port_direction));

    reset_wdt_model far (.core_clk(core_clk), .pin_req(pin_req), .wdt_fire(wdt_fire),
        .wdt_clear(wdt_clear), .ext_reset_pin_n(ext_reset_pin_n), .wdt_timeout(wdt_timeout));

    always #2.5 core_clk = ~core_clk;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ceiling: six sequences of about 1100 cycles plus register traffic
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic halt();
        @(posedge core_clk);
        halt_exec <= 1'b1;
        @(posedge core_clk);
        halt_exec <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1 chk("halt_flags", 3'b110, {halted, powerdown_flag, timeout_flag});
    endtask

    // kind 0 pin, 1 watchdog, 2 plain wake, 3 power-up release
    task automatic ev(input int kind, input logic to_e, pdf_e, warm, input int bit_i);
        int n, lo;
        logic seen, sc, sp, sl;
        n = 0; seen = 0; sc = 0; sp = 0; sl = 0;
        lo = warm ? STARTUP_CLOCKS : STARTUP_CLOCKS + OPTLOAD_CYCLES;
        @(posedge core_clk);
        if (kind == 0)
        begin
            pin_req <= 1'b1;
            repeat (40) @(posedge core_clk);
            chk("hold_pin_low", 1, cpu_hold);
            pin_req <= 1'b0;
        end
        else if (kind == 1) wdt_fire <= 1'b1;
        else if (kind == 2) wake_event <= 1'b1;
        else arst_n <= 1'b1;
        @(posedge core_clk);
        wdt_fire <= 1'b0; wake_event <= 1'b0;
        while (n < 1300 && !(seen && cpu_hold === 1'b0))
        begin
            @(posedge core_clk);
            #1 n++;
            seen |= cpu_hold === 1'b1;
            sc |= chip_reset === 1'b1;
            sp |= pc_sp_clear === 1'b1;
            sl |= (wdt_clear & int_disable & prescaler_clear & timers_off & ports_input) === 1'b1;
        end
        chk("hold_len_ok", 1, n >= lo && n <= lo + 12);
        chk("chip_reset", !warm, sc);
        chk("pc_sp_clear", kind != 2, sp);
        chk("chip_clears", !warm, sl);
        chk("pc_sp_vals", {PC_RESET, SP_TOP}, {pc_reset_value, sp_reset_value});
        chk("flags", {to_e, pdf_e}, {timeout_flag, powerdown_flag});
        chk("init_vals", {WDT_PRESCALE_RST, TIMER0_CONTROL_RST, WATCHDOG_CONTROL_RST, PORT_LATCH_RST, PORT_DIR_RST},
            {watchdog_prescale_select, timer0_control, watchdog_control, io_port_latch, io_port_direction});
        rd(REG_FLAGS, d);
        chk("flags_reg", {6'h00, pdf_e, to_e}, d);
        if (bit_i >= 0)
        begin
            rd(REG_STATUS, d);
            chk("status_bit", 1, d[bit_i]);
            wr(REG_MASK, 8'h01 << bit_i);
            repeat (2) @(posedge core_clk);
            #1 chk("irq_on", 1, irq);
            wr(REG_MASK, 8'h00);
            repeat (2) @(posedge core_clk);
            #1 chk("irq_masked", 0, irq);
            wr(REG_STATUS, 8'h0F);
            rd(REG_STATUS, d);
            chk("status_w1c", 0, d);
        end
    endtask

    initial
    begin
        seed = 73; fail_count = 0; samples_checked = 0; cycles = 0; core_clk = 0; arst_n = 0;
        pin_req = 0; wdt_fire = 0; halt_exec = 0; wdt_clear_exec = 0; wake_event = 0;
        reg_addr = 4'h0; reg_wdata = 8'h00; reg_wr = 0; reg_rd = 0;
        repeat (2) @(posedge core_clk);
        #1 chk("por_state", 4'b1100, {chip_reset, cpu_hold, timeout_flag, powerdown_flag});
        ev(3, 0, 0, 0, -1);
        for (int i = 0; i < 16; i++)
        begin
            e = 8'($random(seed));
            wr(REG_MASK, e);
            rd(REG_MASK, d);
            chk("mask_rdbk", {4'h0, e[3:0]}, d);
            wr(4'h3 + 4'($unsigned($random(seed)) % 13), e);
            rd(4'h3 + 4'(i % 13), d);
            chk("unmapped", 0, d);
        end
        wr(REG_MASK, 8'h00);
        wr(REG_STATUS, 8'h0F);
        ev(1, 1, 0, 0, EV_WDT_RUN);
        ev(0, 1, 0, 0, EV_PIN_RUN);
        halt();
        ev(2, 0, 1, 1, -1);
        @(posedge core_clk);
        wdt_clear_exec <= 1'b1;
        @(posedge core_clk);
        wdt_clear_exec <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1 chk("pdf_clear", 0, powerdown_flag);
        halt();
        ev(1, 1, 1, 1, EV_WDT_HALT);
        halt();
        ev(0, 0, 1, 0, EV_PIN_HALT);
        end_of_test();
    end
endmodule
